// ==== design/srba_bank.sv ====
// Purpose: Serial-framed register bank with control, read/clear status and level registers.
// Assumes: Frames are 16 bits, least significant bit first, data sampled on rising clock.
// Notes:   The serial clock is oversampled; it must be below a sixth of core_clk.
//
// Contract
// - A frame is sixteen bits: address, access bit, then one data byte.
// - Access bit zero reads and leaves the register unchanged; the code clears returned read/clear status flags on any access.
// - Access bit one writes the whole data byte into the register; the code stores only the CTRL_WMASK bits of a control register.
// - Data bits zero to seven sit at frame bits eight to fifteen.
// - Reserved bits always read as zero.
// - Power-on or commanded soft reset loads every reset value.
// - Restart loads restart values; bits marked keep hold their content.
// - Read-only bits ignore writes and show device values.
// - Read/write bits store the written value and return it.
// - Hardware-modifiable bits take host writes and device updates.
// - Other control bits change only through host writes.
// - Each register has one address; one register per frame.
// - During a write the returned data is the content before the write.
`timescale 1ns/1ps
`default_nettype none
module srba_bank #(
  parameter int FRAME_LEN = srba_pkg::FRAME_BITS
) (
  input  wire logic                            core_clk,
  input  wire logic                            resetn,
  input  wire logic                            spi_clk,
  input  wire logic                            spi_sel_n,
  input  wire logic                            spi_mosi,
  output logic                                 spi_miso,
  output logic                                 spi_miso_oe,
  input  wire logic                            supervisor_restart_state,
  input  wire logic [srba_pkg::NUM_CTRL-1:0]   hw_write_en,
  input  wire logic [srba_pkg::NUM_CTRL*8-1:0] hw_write_data,
  input  wire logic [srba_pkg::NUM_STAT*8-1:0] status_set,
  input  wire logic [7:0]                      wake_level_in,
  output logic [srba_pkg::NUM_CTRL*8-1:0]      ctrl_out,
  output logic                                 commanded_soft_reset,
  output logic                                 frame_error
);
  localparam int NC = srba_pkg::NUM_CTRL;
  localparam int NS = srba_pkg::NUM_STAT;

  if (FRAME_LEN != srba_pkg::FRAME_BITS) begin : g_chk
    $error("Only sixteen-bit frames are supported.");
  end

  logic [2:0] clk_s1, clk_s2;
  logic [7:0] lvl_s1, lvl_s2;
  logic       clk_q;
  logic       sel_q;
  logic       rise, fall, sel_start, sel_end;
  logic [srba_pkg::CNT_BITS-1:0] cnt;
  logic [15:0] rx;
  logic [15:0] tx_sh;
  logic [7:0]  rd_lat;
  logic [7:0]  rc_seen;
  logic [7:0]  ctrl [NC];
  logic [7:0]  stat [NS];
  logic        restart_q;
  logic        restart_rise;
  logic        soft_pend;
  logic        commit;
  logic        is_write;
  logic [6:0]  addr;
  logic [7:0]  wdat;
  logic        c_hit, s_hit;
  logic [4:0]  c_idx;
  logic [3:0]  s_idx;
  logic [7:0]  rd_data;
  logic [7:0]  summary;

  // Pins cross into core_clk through two flip-flops; only the second stage is read.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      // Reset to the idle levels, select high and clock low, so no false edge follows reset.
      clk_s1 <= 3'h4;
      clk_s2 <= 3'h4;
      lvl_s1 <= 8'h00;
      lvl_s2 <= 8'h00;
    end else begin
      clk_s1 <= {spi_sel_n, spi_clk, spi_mosi};
      clk_s2 <= clk_s1;
      lvl_s1 <= wake_level_in;
      lvl_s2 <= lvl_s1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      clk_q <= 1'b0;
      sel_q <= 1'b0;
    end else begin
      clk_q <= clk_s2[1];
      sel_q <= !clk_s2[2];
    end
  end

  assign rise      = clk_s2[1] && !clk_q && sel_q;
  assign fall      = !clk_s2[1] && clk_q && sel_q;
  assign sel_start = !clk_s2[2] && !sel_q;
  assign sel_end   = clk_s2[2] && sel_q;
  assign commit    = sel_end && (cnt == srba_pkg::CNT_BITS'(FRAME_LEN));
  // Mid-frame the first seven bits still sit at the top of the shift register.
  assign addr      = (cnt == srba_pkg::CNT_BITS'(FRAME_LEN)) ? rx[srba_pkg::ADDR_BITS-1:0] :
                     rx[FRAME_LEN-srba_pkg::ADDR_BITS +: srba_pkg::ADDR_BITS];
  assign is_write  = rx[srba_pkg::RW_BIT];
  assign wdat      = rx[srba_pkg::DATA_LSB +: 8];

  // Address decode: each register owns exactly one address.
  always_comb begin
    c_hit = 1'b0;
    s_hit = 1'b0;
    c_idx = 5'h00;
    s_idx = 4'h0;
    for (int i = 0; i < NC; i++) begin
      if (addr == srba_pkg::CTRL_ADDR[i]) begin
        c_hit = 1'b1;
        c_idx = 5'(i);
      end
    end
    for (int j = 0; j < NS; j++) begin
      if (addr == srba_pkg::STAT_ADDR[j]) begin
        s_hit = 1'b1;
        s_idx = 4'(j);
      end
    end
  end

  always_comb begin
    if (c_hit) begin
      rd_data = ctrl[c_idx] & srba_pkg::CTRL_WMASK[c_idx];
    end else if (s_hit) begin
      rd_data = stat[s_idx] & srba_pkg::STAT_VMASK[s_idx];
    end else begin
      rd_data = srba_pkg::BYTE_ZERO;
    end
  end

  // The first returned byte flags which of the first eight status registers hold events.
  always_comb begin
    summary = 8'h00;
    for (int j = 0; j < 8; j++) begin
      summary[j] = |stat[j];
    end
  end

  // Receive side: bits arrive least significant first on rising serial clock edges.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= '0;
      rx  <= 16'h0000;
    end else if (sel_start) begin
      cnt <= '0;
    end else if (rise) begin
      rx <= {clk_s2[0], rx[15:1]};
      if (cnt != '1) begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  // Transmit side. The data byte is captured once the address is in, before any write.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_sh       <= 16'h0000;
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
      rd_lat      <= 8'h00;
      rc_seen     <= 8'h00;
    end else begin
      spi_miso_oe <= !clk_s2[2];
      if (sel_start) begin
        spi_miso <= summary[0];
        tx_sh    <= {9'h000, summary[7:1]};
        rc_seen  <= 8'h00;
      end else if (rise && cnt == srba_pkg::CNT_BITS'(srba_pkg::DATA_LSB - 1)) begin
        tx_sh  <= {8'h00, rd_data};
        rd_lat <= rd_data;
        if (s_hit && srba_pkg::STAT_RC[s_idx]) begin
          rc_seen <= rd_data;
        end else begin
          rc_seen <= 8'h00;
        end
      end else if (fall) begin
        spi_miso <= tx_sh[0];
        tx_sh    <= {1'b0, tx_sh[15:1]};
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      frame_error <= 1'b0;
    end else begin
      frame_error <= sel_end && !commit;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      restart_q            <= 1'b0;
      soft_pend            <= 1'b0;
      commanded_soft_reset <= 1'b0;
    end else begin
      restart_q            <= supervisor_restart_state;
      soft_pend            <= commit && is_write && c_hit &&
                              c_idx == 5'(srba_pkg::MSCTRL_IDX) &&
                              wdat[srba_pkg::MODE_LSB +: 2] == srba_pkg::MODE_SOFT_RESET;
      commanded_soft_reset <= soft_pend;
    end
  end
  assign restart_rise = supervisor_restart_state && !restart_q;

  // Control registers. Reset and restart take priority; a host write beats a device update.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NC; i++) begin
        ctrl[i] <= srba_pkg::CTRL_POR[i];
      end
    end else begin
      for (int i = 0; i < NC; i++) begin
        if (soft_pend) begin
          ctrl[i] <= srba_pkg::CTRL_POR[i];
        end else if (restart_rise) begin
          ctrl[i] <= (ctrl[i] & srba_pkg::CTRL_KEEP[i]) |
                     (srba_pkg::CTRL_RSTV[i] & ~srba_pkg::CTRL_KEEP[i]);
        end else if (commit && is_write && c_hit && c_idx == 5'(i)) begin
          ctrl[i] <= wdat & srba_pkg::CTRL_WMASK[i];
        end else if (hw_write_en[i]) begin
          ctrl[i] <= (ctrl[i] & ~srba_pkg::CTRL_HMASK[i]) |
                     (hw_write_data[i*8 +: 8] & srba_pkg::CTRL_HMASK[i]);
        end
      end
    end
  end

  for (genvar g = 0; g < NC; g++) begin : g_out
    assign ctrl_out[g*8 +: 8] = ctrl[g];
  end

  // Status flags. A new event in the clearing cycle survives because the set is ORed last.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int j = 0; j < NS; j++) begin
        stat[j] <= 8'h00;
      end
    end else begin
      for (int j = 0; j < NS; j++) begin
        if (!srba_pkg::STAT_RC[j]) begin
          stat[j] <= lvl_s2 & srba_pkg::STAT_VMASK[j];
        end else if (soft_pend) begin
          stat[j] <= status_set[j*8 +: 8] & srba_pkg::STAT_VMASK[j];
        end else if (commit && s_hit && s_idx == 4'(j)) begin
          stat[j] <= (stat[j] & ~rc_seen) |
                     (status_set[j*8 +: 8] & srba_pkg::STAT_VMASK[j]);
        end else begin
          stat[j] <= stat[j] | (status_set[j*8 +: 8] & srba_pkg::STAT_VMASK[j]);
        end
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  logic quiet;
  assign quiet = !restart_rise && !soft_pend && hw_write_en == '0;

  property p_frame_len;
    sel_end && cnt != srba_pkg::CNT_BITS'(FRAME_LEN) |=> frame_error;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("Short frame not flagged.");

  property p_read_keeps;
    commit && !is_write && quiet |=> ctrl_out == $past(ctrl_out);
  endproperty
  a_read_keeps: assert property (p_read_keeps) else $error("Read altered a register.");

  property p_write_stores;
    commit && is_write && c_hit && quiet |=>
      ctrl[$past(c_idx)] == ($past(wdat) & srba_pkg::CTRL_WMASK[$past(c_idx)]);
  endproperty
  a_write_stores: assert property (p_write_stores) else $error("Write not stored.");

  property p_data_bit0;
    fall && cnt == srba_pkg::CNT_BITS'(srba_pkg::DATA_LSB) |=> spi_miso == $past(rd_lat[0]);
  endproperty
  a_data_bit0: assert property (p_data_bit0) else $error("Data bit zero misplaced.");

  property p_reserved_zero;
    c_hit |-> (rd_data & ~srba_pkg::CTRL_WMASK[c_idx]) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bit read one.");

  property p_soft_reset;
    soft_pend |=> ctrl[srba_pkg::MSCTRL_IDX] == srba_pkg::CTRL_POR[srba_pkg::MSCTRL_IDX];
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("Soft reset value not loaded.");

  property p_restart;
    restart_rise && !soft_pend |=> ctrl[srba_pkg::HWCTRL_IDX] ==
      (($past(ctrl[srba_pkg::HWCTRL_IDX]) & srba_pkg::CTRL_KEEP[srba_pkg::HWCTRL_IDX]) |
       (srba_pkg::CTRL_RSTV[srba_pkg::HWCTRL_IDX] & ~srba_pkg::CTRL_KEEP[srba_pkg::HWCTRL_IDX]));
  endproperty
  a_restart: assert property (p_restart) else $error("Restart value wrong.");

  property p_level_ro;
    1'b1 |=> stat[srba_pkg::LVL_IDX] == ($past(lvl_s2) & srba_pkg::STAT_VMASK[srba_pkg::LVL_IDX]);
  endproperty
  a_level_ro: assert property (p_level_ro) else $error("Level register not device driven.");

  property p_rc_clear;
    commit && s_hit && status_set == '0 && !soft_pend |=>
      (stat[$past(s_idx)] & $past(rc_seen)) == 8'h00;
  endproperty
  a_rc_clear: assert property (p_rc_clear) else $error("Reported flags not cleared.");

  property p_stable_ctrl;
    !commit && quiet |=> ctrl_out == $past(ctrl_out);
  endproperty
  a_stable_ctrl: assert property (p_stable_ctrl) else $error("Control changed unbidden.");

  property p_unmapped_zero;
    !c_hit && !s_hit |-> rd_data == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("Unmapped read not zero.");

  property p_soft_pulse;
    soft_pend |=> commanded_soft_reset;
  endproperty
  a_soft_pulse: assert property (p_soft_pulse) else $error("Soft reset pulse missing.");

  property p_unmapped_write;
    commit && is_write && !c_hit && !s_hit && quiet |=> ctrl_out == $past(ctrl_out);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("Unmapped write acted.");

  property p_status_write;
    commit && is_write && s_hit && quiet |=> ctrl_out == $past(ctrl_out);
  endproperty
  a_status_write: assert property (p_status_write) else $error("Status write hit control.");

  property p_set_wins;
    status_set[7:0] != 8'h00 |=>
      (stat[0] & $past(status_set[7:0])) == ($past(status_set[7:0]) & srba_pkg::STAT_VMASK[0]);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("Status event lost.");

  property p_hw_update;
    hw_write_en[srba_pkg::HWCTRL_IDX] && !restart_rise && !soft_pend && !commit |=>
      (ctrl[srba_pkg::HWCTRL_IDX] & srba_pkg::CTRL_HMASK[srba_pkg::HWCTRL_IDX]) ==
      ($past(hw_write_data[srba_pkg::HWCTRL_IDX*8 +: 8]) &
       srba_pkg::CTRL_HMASK[srba_pkg::HWCTRL_IDX]);
  endproperty
  a_hw_update: assert property (p_hw_update) else $error("Device update not taken.");

  property p_hw_keeps_rw;
    hw_write_en[srba_pkg::HWCTRL_IDX] && !restart_rise && !soft_pend && !commit |=>
      (ctrl[srba_pkg::HWCTRL_IDX] & ~srba_pkg::CTRL_HMASK[srba_pkg::HWCTRL_IDX]) ==
      ($past(ctrl[srba_pkg::HWCTRL_IDX]) & ~srba_pkg::CTRL_HMASK[srba_pkg::HWCTRL_IDX]);
  endproperty
  a_hw_keeps_rw: assert property (p_hw_keeps_rw) else $error("Device changed a host bit.");

  property p_one_hit;
    c_hit |-> !s_hit;
  endproperty
  a_one_hit: assert property (p_one_hit) else $error("Address decoded twice.");

  c_write: cover property (commit && is_write && c_hit);
  c_rc_read: cover property (commit && !is_write && s_hit && rc_seen != 8'h00);
  c_restart: cover property (restart_rise);
  c_soft_reset: cover property (soft_pend);
  c_frame_error: cover property (sel_end && !commit);
endmodule : srba_bank
`default_nettype wire

// ==== design/srba_pkg.sv ====
// Purpose: Constants for the serial register bank: frame layout, address map and bit masks.
// Assumes: Byte-wide registers, one per seven-bit address.
// Notes:   Table order is the register index used by the bank.
`default_nettype none
package srba_pkg;
  localparam int NUM_CTRL   = 19;
  localparam int NUM_STAT   = 11;
  localparam int FRAME_BITS = 16;
  localparam int ADDR_BITS  = 7;
  localparam int RW_BIT     = 7;
  localparam int DATA_LSB   = 8;
  localparam int CNT_BITS   = 5;
  localparam int MSCTRL_IDX = 0;
  localparam int HWCTRL_IDX = 1;
  localparam int LVL_IDX    = 8;
  localparam int MODE_LSB   = 6;
  localparam logic [1:0] MODE_SOFT_RESET = 2'h3;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  localparam logic [6:0] CTRL_ADDR [NUM_CTRL] = '{
    7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08, 7'h09, 7'h0C,
    7'h0D, 7'h10, 7'h14, 7'h15, 7'h17, 7'h18, 7'h19, 7'h1C, 7'h1E};
  // Writable bits; every other position is reserved and reads as zero.
  localparam logic [7:0] CTRL_WMASK [NUM_CTRL] = '{
    8'hFF, 8'hFB, 8'hF7, 8'hFB, 8'h20, 8'hC4, 8'hA7, 8'h3F, 8'h3F, 8'h77,
    8'h77, 8'h70, 8'h77, 8'h77, 8'hFF, 8'hFF, 8'hFF, 8'h05, 8'hFF};
  // Bits that device logic may change on its own.
  localparam logic [7:0] CTRL_HMASK [NUM_CTRL] = '{
    8'hFC, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] CTRL_POR [NUM_CTRL] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] CTRL_RSTV [NUM_CTRL] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // Bits that keep their content on restart.
  localparam logic [7:0] CTRL_KEEP [NUM_CTRL] = '{
    8'h23, 8'hD9, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

  localparam logic [6:0] STAT_ADDR [NUM_STAT] = '{
    7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46, 7'h47, 7'h48, 7'h54, 7'h55};
  localparam logic [7:0] STAT_VMASK [NUM_STAT] = '{
    8'h5F, 8'hFF, 8'h07, 8'hCF, 8'h67, 8'h00, 8'h77, 8'h30, 8'hF7, 8'h0F, 8'h0F};
  localparam logic STAT_RC [NUM_STAT] = '{
    1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
endpackage : srba_pkg
`default_nettype wire

// ==== bench/srba_host.sv ====
// Purpose: Host model that drives framed serial transfers into the bank.
// Assumes: The link clock idles low and runs only inside a frame.
// Notes:   Half period 62.5 ns; returned data is sampled on the rising clock.
`timescale 1ns/1ps
`default_nettype none
module srba_host (
  input  wire logic core_clk,
  output logic      spi_clk,
  output logic      spi_sel_n,
  output logic      spi_mosi,
  input  wire logic spi_miso,
  input  wire logic spi_miso_oe
);
  initial begin
    spi_clk   = 1'b0;
    spi_sel_n = 1'b1;
    spi_mosi  = 1'b1;
  end

  // A count other than sixteen is only sent on purpose, to see it refused.
  task automatic xfer(input logic [15:0] tx, input int nb, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge core_clk);
    #1;
    spi_sel_n = 1'b0;
    spi_mosi  = tx[0];
    #62.5;
    for (int i = 0; i < nb; i++) begin
      spi_clk = 1'b1;
      rx[i]   = spi_miso_oe ? spi_miso : 1'bx;
      #62.5;
      spi_clk = 1'b0;
      if (i < 15) begin
        spi_mosi = tx[i+1];
      end
      #62.5;
    end
    spi_sel_n = 1'b1;
    // A released line shows the inverse of its last bit, so a stale copy cannot pass.
    spi_mosi  = ~spi_mosi;
    repeat (8) @(posedge core_clk);
    #1;
  endtask : xfer
endmodule : srba_host
`default_nettype wire

// ==== bench/tb.sv ====
// Purpose: Self-checking bench for the serial register bank.
// Assumes: The host model drives the link; all other inputs are driven here.
// Notes:   Expected values come from the package tables and masks.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic         core_clk = 1'b0;
  logic         resetn   = 1'b0;
  logic         spi_clk, spi_sel_n, spi_mosi, spi_miso, spi_miso_oe;
  logic         restart  = 1'b0;
  logic [18:0]  hw_en    = '0;
  logic [151:0] hw_data  = '0;
  logic [87:0]  st_set   = '0;
  logic [7:0]   lvl      = 8'hFF;
  logic [151:0] ctrl_out, snap;
  logic         soft_rst, frame_err;
  logic [15:0]  rx;
  logic [7:0]   v, e;
  logic [6:0]   a;
  int           n_mismatch = 0;
  int           num_checks = 0;
  int           n_sr       = 0;
  int           n_fe       = 0;

  always #4 core_clk = ~core_clk;

  srba_host host (.core_clk(core_clk), .spi_clk(spi_clk), .spi_sel_n(spi_sel_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));

  srba_bank dut (.core_clk(core_clk), .resetn(resetn), .spi_clk(spi_clk),
    .spi_sel_n(spi_sel_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .supervisor_restart_state(restart), .hw_write_en(hw_en),
    .hw_write_data(hw_data), .status_set(st_set), .wake_level_in(lvl),
    .ctrl_out(ctrl_out), .commanded_soft_reset(soft_rst), .frame_error(frame_err));

  always @(posedge core_clk) begin
    if (soft_rst === 1'b1) n_sr++;
    if (frame_err === 1'b1) n_fe++;
  end

  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask : tick

  task automatic chk(input logic [151:0] got, input logic [151:0] exp_v);
    num_checks++;
    if (got !== exp_v) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp_v);
    end
  endtask : chk

  task automatic xf(input logic [6:0] ad, input logic w, input logic [7:0] d,
                    output logic [7:0] q);
    logic [15:0] r;
    host.xfer({d, w, ad}, 16, r);
    q = r[15:8];
  endtask : xf

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  initial begin
    #600000;
    n_mismatch++;
    complete_run();
  end

  initial begin
    repeat (3) @(posedge core_clk);
    #1 resetn = 1'b1;
    repeat (3) tick();
    for (int i = 0; i < 19; i++) begin
      a = srba_pkg::CTRL_ADDR[i];
      xf(a, 1'b0, 8'hFF, v);
      chk(v, srba_pkg::CTRL_POR[i]);
      e = (8'h5A ^ 8'(i)) & srba_pkg::CTRL_WMASK[i];
      xf(a, 1'b1, e, v);
      chk(ctrl_out[8*i +: 8], e);
      // Reserved bits are set here on purpose, to see them read back as zero.
      xf(a, 1'b1, 8'hA5 ^ 8'(i), v);
      chk(v, e);
      e = (8'hA5 ^ 8'(i)) & srba_pkg::CTRL_WMASK[i];
      xf(a, 1'b0, 8'hFF, v);
      chk(v, e);
      chk(ctrl_out[8*i +: 8], e);
    end
    for (int i = 0; i < 19; i++) begin
      chk(ctrl_out[8*i +: 8], (8'hA5 ^ 8'(i)) & srba_pkg::CTRL_WMASK[i]);
    end
    snap = ctrl_out;
    xf(7'h0A, 1'b1, 8'hFF, v);
    xf(7'h7F, 1'b0, 8'hFF, v);
    chk(v, 8'h00);
    host.xfer(16'hFF83, 8, rx);
    chk(ctrl_out, snap);
    chk(n_fe, 1);
    hw_data = {19{8'hBE}};
    tick();
    hw_en = '1;
    tick();
    hw_en = '0;
    repeat (2) tick();
    for (int i = 0; i < 19; i++) begin
      e = (snap[8*i +: 8] & ~srba_pkg::CTRL_HMASK[i]) | (8'hBE & srba_pkg::CTRL_HMASK[i]);
      chk(ctrl_out[8*i +: 8], e);
    end
    snap = ctrl_out;
    restart = 1'b1;
    repeat (2) tick();
    restart = 1'b0;
    repeat (2) tick();
    for (int i = 0; i < 19; i++) begin
      e = (snap[8*i +: 8] & srba_pkg::CTRL_KEEP[i]) |
          (srba_pkg::CTRL_RSTV[i] & ~srba_pkg::CTRL_KEEP[i]);
      chk(ctrl_out[8*i +: 8], e);
    end
    for (int j = 0; j < 11; j++) begin
      a = srba_pkg::STAT_ADDR[j];
      e = srba_pkg::STAT_RC[j] ? 8'h00 : srba_pkg::STAT_VMASK[j];
      tick();
      st_set[8*j +: 8] = 8'hFF;
      tick();
      st_set = '0;
      xf(a, 1'b0, 8'hFF, v);
      chk(v, srba_pkg::STAT_VMASK[j]);
      xf(a, 1'b1, 8'hFF, v);
      chk(v, e);
      xf(a, 1'b0, 8'hFF, v);
      chk(v, e);
    end
    tick();
    st_set[15:8] = 8'hFF;
    tick();
    st_set = '0;
    xf(7'h01, 1'b1, 8'hC0, v);
    chk(n_sr, 1);
    for (int i = 0; i < 19; i++) begin
      chk(ctrl_out[8*i +: 8], srba_pkg::CTRL_POR[i]);
    end
    xf(7'h41, 1'b0, 8'h00, v);
    chk(v, 8'h00);
    complete_run();
  end
endmodule : tb
`default_nettype wire
